// >>> frc_params.svh
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH

// Register index in the identification read space
`define FRC_RCFG_OFFSET      16'h0005
// Command codes on the data bus
`define FRC_CMD_RCFG_SETUP   16'h0060
`define FRC_CMD_RCFG_CONFIRM 16'h0003
`define FRC_CMD_READ_ARRAY   16'h00ff
`define FRC_CMD_READ_STATUS  16'h0070
`define FRC_CMD_IDENTIFICATION_READ_MODE      16'h0090
// Reset value: asynchronous mode, other bits ignored
`define FRC_RCFG_RESET       16'h8000
// Field positions
`define FRC_BIT_MODE         15
`define FRC_LAT_HI           14
`define FRC_LAT_LO           11
`define FRC_BIT_WPOL         10
`define FRC_BIT_WDLY         8
`define FRC_BIT_BUS          4
`define FRC_BL_HI            2
`define FRC_BL_LO            0
// Latency code limits
`define FRC_LAT_MIN          4'h3
`define FRC_LAT_MAX          4'he
// Burst length codes
`define FRC_BL_WRAP8         3'h2
`define FRC_BL_WRAP16        3'h3
`define FRC_BL_LINEAR        3'h7

`endif

// >>> frc_pkg.sv
package frc_pkg;
	typedef enum logic [1:0] {
		FRC_RD_ARRAY  = 2'h0,
		FRC_RD_STATUS = 2'h1,
		FRC_RD_ID     = 2'h3
	} frc_rdmode_e;

	typedef enum logic [1:0] {
		FRC_B_IDLE = 2'h0,
		FRC_B_WAIT = 2'h1,
		FRC_B_DATA = 2'h3
	} frc_burst_e;

	// Decoded view of the configuration
	typedef struct packed {
		logic       sync_mode;
		logic [3:0] latency;
		logic       wait_high;
		logic       wait_early;
		logic       split_bus;
		logic [2:0] burst_len;
	} frc_cfg_s;
endpackage

// >>> frc_read_config.sv
`timescale 1ns/1ps
`include "frc_params.svh"

// Behaviour
// - Holds a volatile 16-bit read/write read configuration register.
// - In identification read mode, offset 0005h returns the register contents.
// - Reset sets bit 15 (asynchronous); other bits ignored while asynchronous.
// - Bit 15 zero selects synchronous burst, one selects asynchronous.
// - Bits 14:11 latency code 3 through 14; other codes reserved.
// - Bit 10 sets wait polarity: zero active low, one active high.
// - Bit 8 zero releases wait with data, one a cycle earlier.
// - Bit 4 zero separate or shared bus, one split plus shared bus.
// - Bits 2:0 burst: 010 wrap 8, 011 wrap 16, 111 linear.
// - Setup write 0060h then confirm 0003h, value on address 15:0.
// - Accepted setup switches partition to status register reads.
// - Accepted confirm loads value and switches partition to array reads.
module frc_read_config
	import frc_pkg::*;
#(
	parameter int ADDR_W = 16
)
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// Host command write strobe
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [15:0]       wr_data,
	// Host read strobe with address capture
	input  wire logic              rd_en,
	input  wire logic [ADDR_W-1:0] rd_addr,
	// Read path
	output logic      [15:0]       rd_data,
	output logic                   rd_from_reg,
	output frc_rdmode_e            read_mode,
	// Decoded configuration
	output frc_cfg_s               cfg,
	output logic                   cfg_latency_ok,
	output logic                   cfg_burst_ok,
	// Burst timing
	output logic                   wait_out,
	output logic                   data_valid
);

	// Elaboration check: the address bus must carry the whole register value
	if (ADDR_W < 16)
	begin
		$error("ADDR_W must carry the 16-bit register value");
	end

	logic [15:0] rcfg_reg, rcfg_next;
	logic        setup_reg, setup_next;
	frc_rdmode_e mode_reg, mode_next;
	logic [15:0] rdat_reg, rdat_next;
	logic        rsel_reg, rsel_next;

	// Command decode and register loading
	always_comb
	begin
		rcfg_next  = rcfg_reg;
		setup_next = 1'b0;
		mode_next  = mode_reg;
		if (wr_en)
		begin
			if (setup_reg && wr_data == `FRC_CMD_RCFG_CONFIRM)
			begin
				rcfg_next = wr_addr[15:0];
				mode_next = FRC_RD_ARRAY;
			end
			else if (wr_data == `FRC_CMD_RCFG_SETUP)
			begin
				setup_next = 1'b1;
				mode_next  = FRC_RD_STATUS;
			end
			else if (wr_data == `FRC_CMD_READ_ARRAY)
				mode_next = FRC_RD_ARRAY;
			else if (wr_data == `FRC_CMD_READ_STATUS)
				mode_next = FRC_RD_STATUS;
			else if (wr_data == `FRC_CMD_IDENTIFICATION_READ_MODE)
				mode_next = FRC_RD_ID;
		end
	end

	// Register readback in identification mode
	always_comb
	begin
		rdat_next = 16'h0000;
		rsel_next = 1'b0;
		if (rd_en && mode_reg == FRC_RD_ID && rd_addr[15:0] == `FRC_RCFG_OFFSET)
		begin
			rdat_next = rcfg_reg;
			rsel_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			rcfg_reg  <= `FRC_RCFG_RESET;
			setup_reg <= 1'b0;
			mode_reg  <= FRC_RD_ARRAY;
			rdat_reg  <= 16'h0000;
			rsel_reg  <= 1'b0;
		end
		else
		begin
			rcfg_reg  <= rcfg_next;
			setup_reg <= setup_next;
			mode_reg  <= mode_next;
			rdat_reg  <= rdat_next;
			rsel_reg  <= rsel_next;
		end
	end

	assign rd_data     = rdat_reg;
	assign rd_from_reg = rsel_reg;
	assign read_mode   = mode_reg;

	// Field decode; fields ignored while asynchronous
	always_comb
	begin
		cfg.sync_mode  = ~rcfg_reg[`FRC_BIT_MODE];
		cfg.latency    = cfg.sync_mode ? rcfg_reg[`FRC_LAT_HI:`FRC_LAT_LO] : 4'h0;
		cfg.wait_high  = cfg.sync_mode & rcfg_reg[`FRC_BIT_WPOL];
		cfg.wait_early = cfg.sync_mode & rcfg_reg[`FRC_BIT_WDLY];
		cfg.split_bus  = cfg.sync_mode & rcfg_reg[`FRC_BIT_BUS];
		cfg.burst_len  = cfg.sync_mode ? rcfg_reg[`FRC_BL_HI:`FRC_BL_LO] : 3'h0;
	end

	assign cfg_latency_ok = cfg.latency >= `FRC_LAT_MIN && cfg.latency <= `FRC_LAT_MAX;
	assign cfg_burst_ok   = cfg.burst_len == `FRC_BL_WRAP8 ||
		cfg.burst_len == `FRC_BL_WRAP16 || cfg.burst_len == `FRC_BL_LINEAR;

	// Synchronous first-data latency timer
	frc_burst_e  bst_reg, bst_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [4:0]  words_reg, words_next;
	logic        dval_reg, dval_next;
	logic        busy;

	always_comb
	begin
		bst_next   = bst_reg;
		cnt_next   = cnt_reg;
		words_next = words_reg;
		dval_next  = 1'b0;
		case (bst_reg)
			FRC_B_IDLE:
			begin
				if (rd_en && cfg.sync_mode && mode_reg == FRC_RD_ARRAY && cfg_latency_ok)
				begin
					bst_next = FRC_B_WAIT;
					cnt_next = cfg.latency - 4'h1;
				end
			end
			FRC_B_WAIT:
			begin
				if (cnt_reg == 4'h1)
				begin
					bst_next   = FRC_B_DATA;
					dval_next  = 1'b1;
					words_next = 5'h01;
				end
				else
					cnt_next = cnt_reg - 4'h1;
			end
			FRC_B_DATA:
			begin
				dval_next  = 1'b1;
				words_next = words_reg + 5'h01;
				if (!rd_en)
				begin
					bst_next  = FRC_B_IDLE;
					dval_next = 1'b0;
				end
				else if ((cfg.burst_len == `FRC_BL_WRAP8 && words_reg == 5'h08) ||
					(cfg.burst_len == `FRC_BL_WRAP16 && words_reg == 5'h10))
					words_next = 5'h01;
				else if (cfg.burst_len == `FRC_BL_LINEAR)
					words_next = words_reg;
			end
			default:
				bst_next = FRC_B_IDLE;
		endcase
		if (!cfg.sync_mode)
		begin
			bst_next  = FRC_B_IDLE;
			dval_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			bst_reg   <= FRC_B_IDLE;
			cnt_reg   <= 4'h0;
			words_reg <= 5'h00;
			dval_reg  <= 1'b0;
		end
		else
		begin
			bst_reg   <= bst_next;
			cnt_reg   <= cnt_next;
			words_reg <= words_next;
			dval_reg  <= dval_next;
		end
	end

	assign data_valid = dval_reg;

	// Wait indicator: asserted while latency runs, polarity from bit 10
	always_comb
	begin
		busy = bst_reg == FRC_B_WAIT;
		if (cfg.wait_early && cnt_reg == 4'h1)
			busy = 1'b0;
		wait_out = cfg.wait_high ? busy : ~busy;
	end

endmodule

// >>> frc_read_config_chk.sv
`timescale 1ns/1ps
module frc_read_config_chk
	import frc_pkg::*;
#(parameter int ADDR_W = 16)
(
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              nrst,
	// Host side
	input wire logic              wr_en,
	input wire logic              rd_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic [15:0]       wr_data,
	// Device outputs
	input wire logic [15:0]       rd_data,
	input wire logic              rd_from_reg,
	input wire logic              cfg_latency_ok,
	input wire logic              cfg_burst_ok,
	input wire logic              wait_out,
	input wire logic              data_valid,
	input wire frc_rdmode_e       read_mode,
	input wire frc_cfg_s          cfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence setup_s; wr_en && wr_data == 16'h0060; endsequence
	sequence confirm_s; wr_en && wr_data == 16'h0003; endsequence
	sequence burst_s;
		rd_en && !$past(rd_en) && cfg.sync_mode && read_mode == FRC_RD_ARRAY && cfg.latency == 4'h3;
	endsequence
	// Latency code 3: three quiet cycles, then the first word
	sequence latency_run_s; !data_valid [*3] ##1 data_valid; endsequence
	setup_mode_a: assert property (
		setup_s |=> read_mode == FRC_RD_STATUS) else $error("setup mode wrong");
	confirm_load_a: assert property (
		setup_s ##1 confirm_s |=> read_mode == FRC_RD_ARRAY && cfg.sync_mode == !$past(wr_addr[15]))
		else $error("confirm load wrong");
	id_read_a: assert property (
		rd_en && read_mode == FRC_RD_ID && rd_addr == 5 |=> rd_from_reg) else $error("no readback");
	async_quiet_a: assert property (
		!cfg.sync_mode |-> cfg[9:0] == 10'h000) else $error("async fields live");
	reset_async_a: assert property (
		$rose(nrst) |-> !cfg.sync_mode && read_mode == FRC_RD_ARRAY) else $error("reset state");
	lat_code_a: assert property (
		cfg_latency_ok == (cfg.latency >= 4'h3 && cfg.latency <= 4'he)) else $error("latency ok");
	burst_code_a: assert property (
		cfg_burst_ok == (cfg.burst_len inside {3'h2, 3'h3, 3'h7})) else $error("burst ok");
	wait_idle_a: assert property (
		data_valid |-> wait_out == !cfg.wait_high) else $error("wait level");
	first_data_a: assert property (
		burst_s |-> latency_run_s) else $error("first data off time");
	wait_busy_a: assert property (
		burst_s |=> wait_out == cfg.wait_high) else $error("wait not asserted");
	wait_early_a: assert property (
		burst_s ##2 1'b1 |-> wait_out == (cfg.wait_high ^ cfg.wait_early))
		else $error("wait release time");
endmodule

bind frc_read_config frc_read_config_chk #(.ADDR_W(ADDR_W)) chk_u (
	.ref_clk        (ref_clk),
	.nrst           (nrst),
	.wr_en          (wr_en),
	.rd_en          (rd_en),
	.wr_addr        (wr_addr),
	.rd_addr        (rd_addr),
	.wr_data        (wr_data),
	.rd_data        (rd_data),
	.rd_from_reg    (rd_from_reg),
	.cfg_latency_ok (cfg_latency_ok),
	.cfg_burst_ok   (cfg_burst_ok),
	.wait_out       (wait_out),
	.data_valid     (data_valid),
	.read_mode      (read_mode),
	.cfg            (cfg)
);

// >>> frc_host.sv
`timescale 1ns/1ps
module frc_host
(
	// Clock and device answers
	input wire logic        ref_clk,
	input wire logic        rd_from_reg,
	input wire logic        data_valid,
	input wire logic [15:0] rd_data,
	// Host bus
	output logic            wr_en,
	output logic            rd_en,
	output logic [15:0]     wr_addr,
	output logic [15:0]     wr_data,
	output logic [15:0]     rd_addr
);
	// Bus quiet until the first command
	initial
	begin
		{wr_en, rd_en, wr_addr, wr_data, rd_addr} <= '0;
	end
	// One write cycle; held through the sampling edge
	task cmd(input logic [15:0] d, a);
		wr_en <= 1'b1;
		wr_data <= d;
		wr_addr <= a;
		@(posedge ref_clk);
	endtask
	// Release the bus; lines no longer show the last value
	task idle;
		wr_en <= 1'b0;
		wr_data <= ~wr_data;
		wr_addr <= ~wr_addr;
	endtask
	// Setup and confirm back to back, value on address lines
	task prog(input logic [15:0] v);
		cmd(16'h0060, v);
		cmd(16'h0003, v);
		idle();
	endtask
	// Single read, data taken one cycle after the strobe
	task rd(input logic [15:0] a, output logic [15:0] d, output logic f);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
		f = rd_from_reg;
		@(posedge ref_clk);
	endtask
	// Burst: hold the strobe until data_valid; bounded wait of 20 cycles
	task burst(input logic [15:0] a, output int n);
		rd_en <= 1'b1;
		rd_addr <= a;
		n = 0;
		while (n < 20 && data_valid !== 1'b1)
		begin
			@(posedge ref_clk);
			#1 n++;
		end
		rd_en <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule

// >>> frc_read_config_test.sv
`timescale 1ns/1ps
module frc_read_config_test
	import frc_pkg::*;
;
	logic        ref_clk = 0, nrst = 0, f;
	logic [15:0] d;
	wire logic   wr_en, rd_en, rd_from_reg, data_valid, wait_out, cfg_latency_ok, cfg_burst_ok;
	wire logic [15:0] wr_addr, wr_data, rd_addr, rd_data;
	frc_rdmode_e read_mode;
	frc_cfg_s    cfg;
	int          num_errors = 0, total_checks = 0, n;
	logic [3:0]  lat[4] = '{4'h3, 4'he, 4'h2, 4'hf};
	logic [2:0]  bl[4] = '{3'h2, 3'h3, 3'h7, 3'h5};
	initial forever #50 ref_clk = ~ref_clk;
	frc_read_config #(.ADDR_W(16)) dut_u (.ref_clk, .nrst, .wr_en, .wr_addr, .wr_data, .rd_en,
		.rd_addr, .rd_data, .rd_from_reg, .read_mode, .cfg, .cfg_latency_ok, .cfg_burst_ok,
		.wait_out, .data_valid);
	frc_host host_u (.ref_clk, .rd_from_reg, .data_valid, .rd_data, .wr_en, .rd_en, .wr_addr,
		.wr_data, .rd_addr);
	task chk(input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		host_u.cmd(16'h0090, 16'h0000);
		host_u.idle();
		host_u.rd(16'h0005, d, f);
		chk(d, 16'h8000);
		$display("reset test done");
		host_u.cmd(16'h0060, 16'h1d12);
		fork
			host_u.cmd(16'h0003, 16'h1d12);
			#1 chk(16'(read_mode), 16'(FRC_RD_STATUS));
		join
		host_u.idle();
		#1 chk(16'(cfg), 16'(frc_cfg_s'{1'b1, 4'h3, 1'b1, 1'b1, 1'b1, 3'h2}));
		chk(16'(read_mode), 16'(FRC_RD_ARRAY));
		@(posedge ref_clk);
		host_u.burst(16'h0000, n);
		chk(16'(n), 16'h0003);
		host_u.cmd(16'h0090, 16'h0000);
		host_u.idle();
		host_u.rd(16'h0005, d, f);
		chk({d[15:1], f}, 16'h1d13);
		host_u.rd(16'h0006, d, f);
		chk(16'(f), 16'h0000);
		host_u.cmd(16'h0003, 16'h0000);
		host_u.idle();
		host_u.rd(16'h0005, d, f);
		chk(d, 16'h1d12);
		$display("program test done");
		for (int i = 0; i < 4; i++)
		begin
			host_u.prog({1'b0, lat[i], 8'h00, bl[i]});
			#1 chk(16'({cfg_latency_ok, cfg_burst_ok}), 16'({i < 2, i != 3}));
			@(posedge ref_clk);
		end
		host_u.prog(16'h9d12);
		#1 chk(16'(cfg), 16'h0000);
		@(posedge ref_clk);
		host_u.prog(16'h1d12);
		nrst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		#1 chk(16'(cfg), 16'h0000);
		chk(16'(read_mode), 16'(FRC_RD_ARRAY));
		chk(16'(wait_out), 16'h0001);
		chk(16'(data_valid), 16'h0000);
		$display("code and reset test done");
		wrap_up();
	end
endmodule
